//--- core/windowed_watchdog.sv
`timescale 1ns/100ps
module windowed_watchdog
    import wdog_pkg::*;
#(
    parameter int unsigned PRE_DIV = PRESCALE
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // Count clock sources
    input  wire logic        internal_rc_oscillator_i,
    input  wire logic        watchdog_oscillator_source_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [4:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // Outputs
    output logic             chip_reset_o,
    output logic             irq_o
);
    // Prescaler register is 8 bits wide, so larger dividers cannot be served
    if (PRE_DIV < 2 || PRE_DIV > 256) begin : g_bad_div
        $error("PRE_DIV out of range");
    end

    logic [23:0]  tc_reg;
    logic [23:0]  count_reg;
    logic [9:0]   warn_reg;
    logic [23:0]  window_reg;
    logic [4:0]   mode_reg;
    logic [ST_W-1:0] status_reg;
    logic [ST_W-1:0] mask_reg;
    logic [7:0]   pre_reg;
    logic         chip_reset_reg;
    feed_state_t  feed_reg;
    logic         tick;
    logic         pre_tick;
    logic         wr;
    logic         rd;
    logic         feed_wr;
    logic         feed_ok;
    logic         feed_bad;
    logic         early;
    logic         timeout;
    logic         warn_hit;
    logic         fault;
    logic         rst_event;
    logic         irq_event;

    // Source selection and edge detection
    wdog_tick_sync u_tick (
        .clk_i     (clk_i),
        .rst_n_i   (rst_n_i),
        .sel_i     (mode_reg[MODE_CLKSEL]),
        .rc_osc_i  (internal_rc_oscillator_i),
        .wdo_osc_i (watchdog_oscillator_source_i),
        .tick_o    (tick)
    );

    function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
        return a == off;
    endfunction : hit

    // Bus strobes; a single-cycle ack, dropped the cycle after
    assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
    assign rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
    assign feed_wr = wr & hit(wb_adr_i, ADDR_FEED) & wb_sel_i[0];

    // Feed sequence decode: key A then key B; any other write in between is bad
    assign feed_ok  = feed_wr && feed_reg == FEED_GOT_A && wb_dat_i[7:0] == FEED_KEY_B;
    assign feed_bad = mode_reg[MODE_EN] &&
                      ((feed_wr && feed_reg == FEED_GOT_A && wb_dat_i[7:0] != FEED_KEY_B) ||
                       (wr && !hit(wb_adr_i, ADDR_FEED) && feed_reg == FEED_GOT_A));
    // Reload above window value means too early
    assign early    = mode_reg[MODE_WINDOW] && count_reg > window_reg;

    assign pre_tick = tick && pre_reg == 8'(PRE_DIV - 1);
    assign timeout  = mode_reg[MODE_EN] && pre_tick && count_reg == 24'h00_0000;
    assign warn_hit = mode_reg[MODE_EN] && pre_tick && count_reg == {14'h0000, warn_reg} &&
                      warn_reg != 10'h000;
    assign fault    = feed_bad || (mode_reg[MODE_EN] && feed_ok && early);
    assign rst_event = mode_reg[MODE_RESET] && (timeout || fault);
    assign irq_event = timeout || fault;

    // Feed sequence tracker
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            feed_reg <= FEED_IDLE;
        end else if (feed_wr && wb_dat_i[7:0] == FEED_KEY_A && feed_reg == FEED_IDLE) begin
            feed_reg <= FEED_GOT_A;
        end else if (wr) begin
            feed_reg <= FEED_IDLE;
        end
    end

    // Fixed prescaler on count clock ticks, cleared by a good feed
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pre_reg <= 8'h00;
        end else if (feed_ok && !fault) begin
            pre_reg <= 8'h00;
        end else if (tick) begin
            pre_reg <= pre_tick ? 8'h00 : pre_reg + 8'h01;
        end
    end

    // Down counter with reload
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_reg <= TC_RST;
        end else if ((feed_ok && !fault) || !mode_reg[MODE_EN]) begin
            count_reg <= tc_reg;
        end else if (pre_tick && count_reg != 24'h00_0000) begin
            count_reg <= count_reg - 24'h00_0001;
        end
    end

    // Time-out constant, floor of 0xFF
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tc_reg <= TC_RST;
        end else if (wr && hit(wb_adr_i, ADDR_TC)) begin
            tc_reg <= (wb_dat_i[23:0] < TC_MIN) ? TC_MIN : wb_dat_i[23:0];
        end
    end

    // Warning and window compare values
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            warn_reg   <= WARN_RST[9:0];
            window_reg <= WIN_RST;
        end else if (wr && hit(wb_adr_i, ADDR_WARN)) begin
            warn_reg <= wb_dat_i[9:0];
        end else if (wr && hit(wb_adr_i, ADDR_WINDOW)) begin
            window_reg <= wb_dat_i[23:0];
        end
    end

    // Mode: enable and reset-select stick once set; event clears enable
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_reg <= 5'h00;
        end else begin
            if (wr && hit(wb_adr_i, ADDR_MODE)) begin
                mode_reg[MODE_EN]     <= mode_reg[MODE_EN] | wb_dat_i[MODE_EN];
                mode_reg[MODE_RESET]  <= mode_reg[MODE_RESET] | wb_dat_i[MODE_RESET];
                mode_reg[MODE_WINDOW] <= wb_dat_i[MODE_WINDOW];
                mode_reg[MODE_CLKSEL] <= wb_dat_i[MODE_CLKSEL];
                if (wb_dat_i[MODE_WDRESET]) begin
                    mode_reg[MODE_WDRESET] <= 1'b0;
                end
            end
            if (irq_event) begin
                mode_reg[MODE_EN] <= 1'b0;
            end
            if (rst_event) begin
                mode_reg[MODE_WDRESET] <= 1'b1;
            end
        end
    end

    // Chip reset pulse, one cycle per event
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            chip_reset_reg <= 1'b0;
        end else begin
            chip_reset_reg <= rst_event;
        end
    end
    assign chip_reset_o = chip_reset_reg;

    // Sticky status, set wins over write-one-clear
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            status_reg <= '0;
        end else begin
            if (wr && hit(wb_adr_i, ADDR_STATUS)) begin
                status_reg <= status_reg & ~wb_dat_i[ST_W-1:0];
            end
            if (warn_hit) begin
                status_reg[ST_WARN] <= 1'b1;
            end
            if (timeout) begin
                status_reg[ST_TIMEOUT] <= 1'b1;
            end
            if (fault) begin
                status_reg[ST_FAULT] <= 1'b1;
            end
        end
    end

    // Interrupt mask
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mask_reg <= '0;
        end else if (wr && hit(wb_adr_i, ADDR_MASK)) begin
            mask_reg <= wb_dat_i[ST_W-1:0];
        end
    end
    assign irq_o = |(status_reg & mask_reg);

    // Ack and read data
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
            if (rd) begin
                case (wb_adr_i)
                    ADDR_MODE:   wb_dat_o <= {27'h000_0000, mode_reg};
                    ADDR_TC:     wb_dat_o <= {8'h00, tc_reg};
                    ADDR_COUNT:  wb_dat_o <= {8'h00, count_reg};
                    ADDR_WARN:   wb_dat_o <= {22'h00_0000, warn_reg};
                    ADDR_WINDOW: wb_dat_o <= {8'h00, window_reg};
                    ADDR_STATUS: wb_dat_o <= {29'h0000_0000, status_reg};
                    ADDR_MASK:   wb_dat_o <= {29'h0000_0000, mask_reg};
                    default:     wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule : windowed_watchdog

//--- core/wdog_pkg.sv
// How it works
// - Counter running out without reload asserts internal chip reset, or interrupt when interrupt mode selected.
// - Windowed mode: reload only when count is at or below the programmed window value, else fault.
// - Optional warning interrupt when counter reaches a programmable point.
// - Software sets enable but cannot clear it; only time-out and fault events clear it.
// - Bad feed sequence causes chip reset, or interrupt when interrupt mode selected.
// - Sticky flag records that chip reset came from the watchdog.
// - Counter is 24 bits with programmable reload, clocked through internal prescaler.
// - Time-out from 256x4 to 2^24x4 count clocks, in steps of four.
// - Count clock selectable between internal RC and dedicated watchdog oscillator.
package wdog_pkg;
    localparam int unsigned CNT_W         = 24;
    localparam int unsigned PRESCALE      = 4;
    localparam logic [23:0] TC_MIN        = 24'h00_00FF;
    localparam logic [23:0] TC_RST        = 24'hFF_FFFF;
    localparam logic [23:0] WARN_RST      = 24'h00_0000;
    localparam logic [23:0] WIN_RST       = 24'hFF_FFFF;
    localparam logic [7:0]  FEED_KEY_A    = 8'hAA;
    localparam logic [7:0]  FEED_KEY_B    = 8'h55;
    // Word offsets (byte address)
    localparam logic [4:0]  ADDR_MODE     = 5'h00;
    localparam logic [4:0]  ADDR_TC       = 5'h04;
    localparam logic [4:0]  ADDR_FEED     = 5'h08;
    localparam logic [4:0]  ADDR_COUNT    = 5'h0C;
    localparam logic [4:0]  ADDR_WARN     = 5'h10;
    localparam logic [4:0]  ADDR_WINDOW   = 5'h14;
    localparam logic [4:0]  ADDR_STATUS   = 5'h18;
    localparam logic [4:0]  ADDR_MASK     = 5'h1C;
    // Mode bits
    localparam int unsigned MODE_EN       = 0;
    localparam int unsigned MODE_RESET    = 1;
    localparam int unsigned MODE_WINDOW   = 2;
    localparam int unsigned MODE_CLKSEL   = 3;
    localparam int unsigned MODE_WDRESET  = 4;
    // Status bits
    localparam int unsigned ST_WARN       = 0;
    localparam int unsigned ST_TIMEOUT    = 1;
    localparam int unsigned ST_FAULT      = 2;
    localparam int unsigned ST_W          = 3;
    typedef enum logic [1:0] {FEED_IDLE, FEED_GOT_A} feed_state_t;
endpackage : wdog_pkg

//--- core/wdog_tick_sync.sv
`timescale 1ns/100ps
// Selects the count clock source and turns its rising edges into one-cycle ticks
module wdog_tick_sync (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    // Sources
    input  wire logic sel_i,
    input  wire logic rc_osc_i,
    input  wire logic wdo_osc_i,
    // Tick
    output logic      tick_o
);
    logic       src;
    logic [2:0] sync_reg;

    // Mux before the synchroniser so only one crossing is needed
    assign src = sel_i ? wdo_osc_i : rc_osc_i;

    // Two stages settle, third gives the edge reference
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync_reg <= 3'h0;
        end else begin
            sync_reg <= {sync_reg[1:0], src};
        end
    end

    assign tick_o = sync_reg[1] & ~sync_reg[2];
endmodule : wdog_tick_sync

//--- tb/wdog_props.sv
`timescale 1ns/100ps
module wdog_props
    import wdog_pkg::*;
#(
    parameter int unsigned PRE_DIV = PRESCALE
) (
    // Clock and reset
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    // Sources
    input wire logic        internal_rc_oscillator_i,
    input wire logic        watchdog_oscillator_source_i,
    // Bus
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [4:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // Outputs
    input wire logic        chip_reset_o,
    input wire logic        irq_o
);
    logic take;
    logic en_s;
    logic rs_s;
    logic wf_s;
    // Write accepted at this edge
    assign take = wb_cyc_i & wb_stb_i & wb_we_i & !wb_ack_o;
    // Shadow of set-only bits; flag set wins over clear
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            en_s <= 1'b0;
            rs_s <= 1'b0;
            wf_s <= 1'b0;
        end else begin
            if (take && wb_adr_i == ADDR_MODE && wb_dat_i[MODE_EN]) en_s <= 1'b1;
            if (take && wb_adr_i == ADDR_MODE && wb_dat_i[MODE_RESET]) rs_s <= 1'b1;
            if (take && wb_adr_i == ADDR_MODE && wb_dat_i[MODE_WDRESET]) wf_s <= 1'b0;
            if (chip_reset_o) wf_s <= 1'b1;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing");
    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_count_width: assert property (wb_ack_o && !wb_we_i && wb_adr_i == ADDR_COUNT
        |-> wb_dat_o[31:24] == 8'h00) else $error("count wider than 24 bits");
    a_tc_floor: assert property (wb_ack_o && !wb_we_i && wb_adr_i == ADDR_TC
        |-> wb_dat_o[31:24] == 8'h00 && wb_dat_o[23:0] >= TC_MIN) else $error("bad reload");
    a_mask_quiet: assert property (take && wb_adr_i == ADDR_MASK && wb_dat_i[2:0] == 3'h0
        |=> !irq_o) else $error("irq while masked");
    a_flag_kept: assert property (wb_ack_o && !wb_we_i && wb_adr_i == ADDR_MODE && wf_s
        |-> wb_dat_o[MODE_WDRESET]) else $error("reset flag lost");
    a_reset_cause: assert property (chip_reset_o |-> rs_s && en_s)
        else $error("reset without cause");
    a_reset_pulse: assert property ($rose(chip_reset_o) |=> !chip_reset_o)
        else $error("reset pulse too long");
endmodule : wdog_props

bind windowed_watchdog wdog_props #(.PRE_DIV(PRE_DIV)) i_props (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .internal_rc_oscillator_i(internal_rc_oscillator_i),
    .watchdog_oscillator_source_i(watchdog_oscillator_source_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .chip_reset_o(chip_reset_o), .irq_o(irq_o));

//--- tb/tb_top.sv
`timescale 1ns/100ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin error_cnt++; \
    $display("unexpected at %0t: %h vs %h", $time, (a), (e)); end end
module tb_top
    import wdog_pkg::*;
;
    typedef struct packed {logic w; logic [4:0] a; logic [23:0] d; logic [23:0] e;} row_t;
    logic        clk_i   = 1'b0;
    logic        rst_n_i = 1'b0;
    logic [3:0]  osc     = 4'h0;
    logic        cyc     = 1'b0;
    logic        we      = 1'b0;
    logic [4:0]  adr     = 5'h00;
    logic [31:0] wdat    = 32'h0000_0000;
    logic [31:0] rdat;
    logic [31:0] q;
    logic        ack;
    logic        crst;
    logic        irq;
    int          error_cnt = 0;
    int          n_checks  = 0;
    int          n_rst     = 0;
    // Reset values, clamp, idle count follows reload, source select, unmapped read
    row_t rows [14] = '{
        '{1'b0, ADDR_MODE, 24'h00_0000, 24'h00_0000}, '{1'b0, ADDR_TC, 24'h00_0000, TC_RST},
        '{1'b0, ADDR_COUNT, 24'h00_0000, 24'hFF_FFFF}, '{1'b0, ADDR_WARN, 24'h00_0000, WARN_RST},
        '{1'b0, ADDR_WINDOW, 24'h00_0000, WIN_RST}, '{1'b0, ADDR_STATUS, 24'h00_0000, 24'h00_0000},
        '{1'b0, ADDR_MASK, 24'h00_0000, 24'h00_0000}, '{1'b1, ADDR_TC, 24'h00_0010, 24'h00_0000},
        '{1'b0, ADDR_TC, 24'h00_0000, TC_MIN}, '{1'b1, ADDR_TC, 24'h00_1234, 24'h00_0000},
        '{1'b0, ADDR_COUNT, 24'h00_0000, 24'h00_1234}, '{1'b1, ADDR_MODE, 24'h00_0008, 24'h00_0000},
        '{1'b0, ADDR_MODE, 24'h00_0000, 24'h00_0008}, '{1'b0, 5'h01, 24'h00_0000, 24'h00_0000}};
    // Clock, count sources and reset-pulse monitor
    always #4 clk_i = ~clk_i;
    always @(posedge clk_i) osc <= osc + 4'h1;
    always @(posedge clk_i) if (crst === 1'b1) n_rst++;
    windowed_watchdog #(.PRE_DIV(PRESCALE)) i_dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .internal_rc_oscillator_i(osc[1]),
        .watchdog_oscillator_source_i(osc[2]), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .chip_reset_o(crst), .irq_o(irq));
    // Classic cycle: hold until ack is sampled, then drop for one cycle
    task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    task automatic wait_irq();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 40000) begin
            @(posedge clk_i);
            n++;
        end
    endtask : wait_irq
    task automatic end_of_test();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test
    // Hang guard, well past the longest expected run
    initial begin
        #400_000;
        error_cnt++;
        end_of_test();
    end
    initial begin
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        foreach (rows[i]) begin
            wb(rows[i].w, rows[i].a, {8'h00, rows[i].d});
            if (!rows[i].w) `CHK(q, {8'h00, rows[i].e})
        end
        // Early feed in window mode, interrupt only
        wb(1'b1, ADDR_MASK, 32'h0000_0007);
        wb(1'b1, ADDR_WINDOW, 32'h0000_0100);
        wb(1'b1, ADDR_TC, 32'h0000_0200);
        wb(1'b1, ADDR_MODE, 32'h0000_000D);
        wb(1'b1, ADDR_FEED, {24'h00_0000, FEED_KEY_A});
        wb(1'b1, ADDR_FEED, {24'h00_0000, FEED_KEY_B});
        `CHK(irq, 1'b1)
        wb(1'b0, ADDR_STATUS, 32'h0000_0000);
        `CHK(q[2:0], 3'h4)
        wb(1'b0, ADDR_MODE, 32'h0000_0000);
        `CHK(q[MODE_EN], 1'b0)
        wb(1'b1, ADDR_STATUS, 32'h0000_0007);
        `CHK(irq, 1'b0)
        // Software cannot clear enable; good feed restarts the count
        wb(1'b1, ADDR_MODE, 32'h0000_0009);
        wb(1'b1, ADDR_MODE, 32'h0000_0008);
        wb(1'b0, ADDR_MODE, 32'h0000_0000);
        `CHK(q[MODE_EN], 1'b1)
        repeat (200) @(posedge clk_i);
        wb(1'b0, ADDR_COUNT, 32'h0000_0000);
        `CHK(q[23:0] < 24'h00_0200, 1'b1)
        wb(1'b1, ADDR_FEED, {24'h00_0000, FEED_KEY_A});
        wb(1'b1, ADDR_FEED, {24'h00_0000, FEED_KEY_B});
        wb(1'b0, ADDR_COUNT, 32'h0000_0000);
        `CHK(q[23:0] >= 24'h00_01FF, 1'b1)
        // Warning ahead of time-out, then time-out in interrupt mode
        wb(1'b1, ADDR_WARN, 32'h0000_01F0);
        wb(1'b1, ADDR_MASK, 32'h0000_0001);
        wait_irq();
        `CHK(irq, 1'b1)
        wb(1'b0, ADDR_COUNT, 32'h0000_0000);
        `CHK(q[23:0] <= 24'h00_01F0, 1'b1)
        wb(1'b1, ADDR_MASK, 32'h0000_0002);
        wait_irq();
        `CHK(irq, 1'b1)
        wb(1'b0, ADDR_MODE, 32'h0000_0000);
        `CHK(q[MODE_EN], 1'b0)
        `CHK(n_rst, 0)
        // Broken feed in reset mode gives one chip reset and the flag
        wb(1'b1, ADDR_STATUS, 32'h0000_0007);
        wb(1'b1, ADDR_MASK, 32'h0000_0000);
        wb(1'b1, ADDR_MODE, 32'h0000_0003);
        wb(1'b1, ADDR_FEED, {24'h00_0000, FEED_KEY_A});
        wb(1'b1, ADDR_WARN, 32'h0000_0000);
        repeat (2) @(posedge clk_i);
        `CHK(n_rst, 1)
        wb(1'b0, ADDR_MODE, 32'h0000_0000);
        `CHK(q[MODE_WDRESET], 1'b1)
        wb(1'b1, ADDR_MODE, 32'h0000_0010);
        wb(1'b0, ADDR_MODE, 32'h0000_0000);
        `CHK(q[MODE_WDRESET], 1'b0)
        end_of_test();
    end
endmodule : tb_top
